// file: verilog/pkt_pkg.sv
package pkt_pkg;
   // ----------------------------------------
   // clock and ticks
   // ----------------------------------------
   localparam int CLK_HZ = 32'h017d7840;
   localparam int MS_PER_S = 32'h000003e8;
   localparam int RX_TICK_HZ = 32'h00008000;
   localparam int TX_TICK_HZ = 32'h00000800;
   localparam int ACC_W = 25;
   localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
   localparam logic [ACC_W-1:0] RX_INC = ACC_W'(RX_TICK_HZ);
   localparam logic [ACC_W-1:0] TX_INC = ACC_W'(TX_TICK_HZ);
   localparam logic [23:0] CYC_PER_MS = 24'(CLK_HZ / MS_PER_S);
   // ----------------------------------------
   // buffer
   // ----------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [9:0] BUF_MAX = 10'h3fc;
   localparam logic [3:0] STR_MAX = 4'h8;
   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RX_IDLE = 8'h04;
   localparam logic [7:0] OFF_TX_IDLE = 8'h08;
   localparam logic [7:0] OFF_STR_LO = 8'h0c;
   localparam logic [7:0] OFF_STR_HI = 8'h10;
   localparam logic [7:0] OFF_LIMITS = 8'h14;
   localparam logic [7:0] OFF_BIT_CYC = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam int F_MODE = 0;
   localparam int F_UNITS = 4;
   localparam int F_EXT = 8;
   localparam int F_MODEM = 9;
   localparam int F_PAR = 10;
   localparam int F_CBITS = 12;
   localparam int F_MAXBUF = 0;
   localparam int F_STRLEN = 16;
   localparam int F_TRAIL = 24;
   localparam int F_DROPS = 16;
   localparam logic [3:0] RST_CHAR_BITS = 4'ha;
   localparam logic [15:0] RST_BIT_CYC = 16'h0a2c;
   localparam logic [63:0] RST_STR = 64'h0000_0000_0000_000d;
   localparam logic [3:0] RST_STR_LEN = 4'h1;

   typedef enum logic [2:0] {MODE_NONE, MODE_IDLE, MODE_SEND, MODE_CUT, MODE_NINTH} mode_t;
   typedef enum logic [1:0] {UNIT_MS, UNIT_CHAR, UNIT_BIT} unit_t;

   // fractional tick: {tick, next accumulator}
   function automatic logic [ACC_W:0] tick_step(input logic [ACC_W-1:0] acc, input logic [ACC_W-1:0] inc);
      logic [ACC_W:0] s;
      s = {1'b0, acc} + {1'b0, inc};
      if (s >= {1'b0, ACC_MOD}) begin
         return {1'b1, ACC_W'(s - {1'b0, ACC_MOD})};
      end
      return {1'b0, s[ACC_W-1:0]};
   endfunction

   function automatic logic [23:0] unit_len(input logic [1:0] u, input logic [15:0] bc, input logic [3:0] cb);
      logic [23:0] l;
      unique case (u)
         UNIT_MS: l = CYC_PER_MS;
         UNIT_CHAR: l = 24'(bc * cb);
         default: l = {8'h00, bc};
      endcase
      return (l == 24'h0) ? 24'h1 : l;
   endfunction

   // elapsed units count up to the threshold, then expiry waits for the tick grid
   function automatic logic [40:0] timer_step(input logic [23:0] sub, input logic [15:0] u,
                                              input logic [15:0] thr, input logic [23:0] ulen, input logic tick);
      if (u >= thr) begin
         return {tick, sub, u};
      end
      if (sub >= 24'(ulen - 24'h1)) begin
         return {1'b0, 24'h0, 16'(u + 16'h1)};
      end
      return {1'b0, 24'(sub + 24'h1), u};
   endfunction
endpackage

// file: verilog/buf_if.sv
`timescale 1ns/1ps
interface buf_if;
   logic wr_en;
   logic [pkt_pkg::ADDR_W-1:0] wr_addr;
   logic [8:0] wr_data;
   logic [pkt_pkg::ADDR_W-1:0] rd_addr;
   logic [8:0] rd_data;
   modport ctl(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: verilog/pkt_buffer.sv
`timescale 1ns/1ps
module pkt_buffer (
   input wire logic clk,
   buf_if.mem b
);
   // bit 8 of each word is the end mark
   logic [8:0] mem [0:(1 << pkt_pkg::ADDR_W) - 1];

   always_ff @(posedge clk) begin
      if (b.wr_en) begin
         mem[b.wr_addr] <= b.wr_data;
      end
      b.rd_data <= mem[b.rd_addr];
   end
endmodule

// file: verilog/serial_rx_packetizer.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module serial_rx_packetizer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic rx_valid,
   input wire logic [8:0] rx_data,
   input wire logic ext_agreed,
   output logic net_valid,
   output logic [7:0] net_data,
   output logic end_of_packet_marker,
   input wire logic net_ready,
   input wire logic tx_in_valid,
   input wire logic [7:0] tx_in_data,
   input wire logic tx_in_eop,
   output logic tx_in_ready,
   output logic ser_tx_valid,
   output logic [7:0] ser_tx_data,
   input wire logic ser_tx_ready,
   output logic modem_server_mode,
   output logic parity_check_en
);
   typedef struct packed {
      logic wb_ack;
      logic [31:0] wb_dat;
      logic [2:0] mode;
      logic [1:0] units;
      logic ext_en;
      logic modem;
      logic par_en;
      logic [3:0] char_bits;
      logic [15:0] rx_idle;
      logic [15:0] tx_idle;
      logic [15:0] bit_cyc;
      logic [63:0] str;
      logic [9:0] max_buf;
      logic [3:0] str_len;
      logic [3:0] trail;
      logic [8:0][7:0] hist;
      logic [3:0] hcnt;
      logic close;
      logic trail_act;
      logic [3:0] trail_cnt;
      logic [9:0] wr;
      logic [9:0] cmt;
      logic [9:0] rd;
      logic [9:0] pkt_cnt;
      logic fetch;
      logic out_v;
      logic [7:0] out_d;
      logic out_eop;
      logic [pkt_pkg::ACC_W-1:0] rx_acc;
      logic [pkt_pkg::ACC_W-1:0] tx_acc;
      logic rx_run;
      logic [23:0] rx_sub;
      logic [15:0] rx_u;
      logic tx_gap;
      logic [23:0] tx_sub;
      logic [15:0] tx_u;
      logic tx_rdy;
      logic ser_v;
      logic [7:0] ser_d;
      logic ser_eop;
      logic [15:0] drops;
      logic modem_o;
      logic par_o;
   } state_t;

   localparam state_t RST = '{tx_rdy: 1'b1, char_bits: pkt_pkg::RST_CHAR_BITS, bit_cyc: pkt_pkg::RST_BIT_CYC,
                              str: pkt_pkg::RST_STR, str_len: pkt_pkg::RST_STR_LEN, default: '0};

   state_t cur_r;
   state_t cur_nxt;
   buf_if bi();
   pkt_pkg::mode_t eff;
   logic [3:0] slen;
   logic [3:0] dly;
   logic [9:0] lim;
   logic [9:0] level;
   logic rx_fire;
   logic rx_tick;
   logic tx_tick;
   logic idle_fire;
   logic tx_done;
   logic [23:0] ulen;
   logic [31:0] reg_w;
   logic [31:0] reg_m;
   logic wr_go;
   logic wr_eop;
   logic [7:0] wr_byte;
   logic commit;

   pkt_buffer u_buf (
      .clk(clk),
      .b(bi)
   );

   function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // newest byte sits in h[0] and must equal the last terminator character
   function automatic logic str_match(input logic [8:0][7:0] h, input logic [63:0] s, input logic [3:0] len);
      logic m;
      int idx;
      m = 1'b1;
      for (int i = 0; i < 8; i++) begin
         idx = int'(len) - 1 - i;
         if (i < int'(len) && h[i] != s[8*idx +: 8]) begin
            m = 1'b0;
         end
      end
      return m;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      cur_nxt = cur_r;
      bi.rd_addr = cur_r.rd;
      slen = (cur_r.str_len == 4'h0) ? 4'h1 : ((cur_r.str_len > pkt_pkg::STR_MAX) ? pkt_pkg::STR_MAX : cur_r.str_len);
      eff = pkt_pkg::MODE_NONE;
      if (cur_r.ext_en && ext_agreed && cur_r.mode <= 3'h4) begin
         eff = pkt_pkg::mode_t'(cur_r.mode);
      end
      dly = (eff == pkt_pkg::MODE_NONE) ? 4'h0 : ((eff == pkt_pkg::MODE_CUT) ? 4'(slen + 4'h1) : 4'h1);
      lim = (cur_r.max_buf == 10'h0 || cur_r.max_buf > pkt_pkg::BUF_MAX) ? pkt_pkg::BUF_MAX : cur_r.max_buf;
      level = 10'(cur_r.wr - cur_r.rd);
      rx_fire = rx_valid && !cur_r.close && level < pkt_pkg::BUF_MAX;

      // ----------------------------------------
      // register bus
      // ----------------------------------------
      cur_nxt.wb_ack = wb_cyc_i && wb_stb_i && !cur_r.wb_ack;
      cur_nxt.wb_dat = '0;
      reg_w = '0;
      case ({wb_adr_i[7:2], 2'b00})
         pkt_pkg::OFF_CTRL: begin
            reg_w[pkt_pkg::F_MODE +: 3] = cur_r.mode;
            reg_w[pkt_pkg::F_UNITS +: 2] = cur_r.units;
            reg_w[pkt_pkg::F_EXT] = cur_r.ext_en;
            reg_w[pkt_pkg::F_MODEM] = cur_r.modem;
            reg_w[pkt_pkg::F_PAR] = cur_r.par_en;
            reg_w[pkt_pkg::F_CBITS +: 4] = cur_r.char_bits;
         end
         pkt_pkg::OFF_RX_IDLE: reg_w[15:0] = cur_r.rx_idle;
         pkt_pkg::OFF_TX_IDLE: reg_w[15:0] = cur_r.tx_idle;
         pkt_pkg::OFF_STR_LO: reg_w = cur_r.str[31:0];
         pkt_pkg::OFF_STR_HI: reg_w = cur_r.str[63:32];
         pkt_pkg::OFF_LIMITS: begin
            reg_w[pkt_pkg::F_MAXBUF +: 10] = cur_r.max_buf;
            reg_w[pkt_pkg::F_STRLEN +: 4] = cur_r.str_len;
            reg_w[pkt_pkg::F_TRAIL +: 4] = cur_r.trail;
         end
         pkt_pkg::OFF_BIT_CYC: reg_w[15:0] = cur_r.bit_cyc;
         pkt_pkg::OFF_STATUS: reg_w = {cur_r.drops, 6'h00, level};
         default: reg_w = '0;
      endcase
      reg_m = bmerge(reg_w, wb_dat_i, wb_sel_i);
      if (cur_nxt.wb_ack) begin
         cur_nxt.wb_dat = reg_w;
         if (wb_we_i) begin
            case ({wb_adr_i[7:2], 2'b00})
               pkt_pkg::OFF_CTRL: begin
                  cur_nxt.mode = reg_m[pkt_pkg::F_MODE +: 3];
                  cur_nxt.units = reg_m[pkt_pkg::F_UNITS +: 2];
                  cur_nxt.ext_en = reg_m[pkt_pkg::F_EXT];
                  cur_nxt.modem = reg_m[pkt_pkg::F_MODEM];
                  cur_nxt.par_en = reg_m[pkt_pkg::F_PAR];
                  cur_nxt.char_bits = reg_m[pkt_pkg::F_CBITS +: 4];
               end
               pkt_pkg::OFF_RX_IDLE: cur_nxt.rx_idle = reg_m[15:0];
               pkt_pkg::OFF_TX_IDLE: cur_nxt.tx_idle = reg_m[15:0];
               pkt_pkg::OFF_STR_LO: cur_nxt.str[31:0] = reg_m;
               pkt_pkg::OFF_STR_HI: cur_nxt.str[63:32] = reg_m;
               pkt_pkg::OFF_LIMITS: begin
                  cur_nxt.max_buf = reg_m[pkt_pkg::F_MAXBUF +: 10];
                  cur_nxt.str_len = reg_m[pkt_pkg::F_STRLEN +: 4];
                  cur_nxt.trail = reg_m[pkt_pkg::F_TRAIL +: 4];
               end
               pkt_pkg::OFF_BIT_CYC: cur_nxt.bit_cyc = reg_m[15:0];
               pkt_pkg::OFF_STATUS: cur_nxt.drops = 16'h0;
               default: ;
            endcase
         end
      end
      // a drop in the clearing cycle still counts
      if (rx_valid && !rx_fire) begin
         cur_nxt.drops = 16'(cur_nxt.drops + 16'h1);
      end
      cur_nxt.modem_o = cur_r.modem;
      cur_nxt.par_o = cur_r.par_en && eff != pkt_pkg::MODE_NINTH;

      // ----------------------------------------
      // idle timers
      // ----------------------------------------
      {rx_tick, cur_nxt.rx_acc} = pkt_pkg::tick_step(cur_r.rx_acc, pkt_pkg::RX_INC);
      {tx_tick, cur_nxt.tx_acc} = pkt_pkg::tick_step(cur_r.tx_acc, pkt_pkg::TX_INC);
      ulen = pkt_pkg::unit_len(cur_r.units, cur_r.bit_cyc, cur_r.char_bits);
      idle_fire = 1'b0;
      if (rx_fire) begin
         cur_nxt.rx_run = 1'b1;
         cur_nxt.rx_sub = 24'h0;
         cur_nxt.rx_u = 16'h0;
      end else if (cur_r.rx_run) begin
         {idle_fire, cur_nxt.rx_sub, cur_nxt.rx_u} =
            pkt_pkg::timer_step(cur_r.rx_sub, cur_r.rx_u, cur_r.rx_idle, ulen, rx_tick);
         if (idle_fire) begin
            cur_nxt.rx_run = 1'b0;
         end
         idle_fire = idle_fire && eff == pkt_pkg::MODE_IDLE;
      end

      // ----------------------------------------
      // receive write path
      // ----------------------------------------
      wr_go = 1'b0;
      wr_eop = 1'b0;
      wr_byte = 8'h00;
      commit = 1'b0;
      if (cur_r.close || idle_fire) begin
         cur_nxt.close = 1'b0;
         commit = 1'b1;
         cur_nxt.hcnt = 4'h0;
         if (eff == pkt_pkg::MODE_CUT) begin
            // terminator bytes are dropped, the byte before them gets the mark
            if (cur_r.hcnt == dly) begin
               wr_go = 1'b1;
               wr_eop = 1'b1;
               wr_byte = cur_r.hist[slen];
            end
         end else if (cur_r.hcnt != 4'h0) begin
            wr_go = 1'b1;
            wr_eop = 1'b1;
            wr_byte = cur_r.hist[0];
         end
      end else if (rx_fire) begin
         if (dly == 4'h0) begin
            wr_go = 1'b1;
            wr_byte = rx_data[7:0];
            commit = 1'b1;
         end else begin
            if (cur_r.hcnt == dly) begin
               wr_go = 1'b1;
               wr_eop = eff == pkt_pkg::MODE_NINTH && !rx_data[8];
               wr_byte = cur_r.hist[4'(dly - 4'h1)];
               commit = wr_eop;
            end
            cur_nxt.hist = {cur_r.hist[7:0], rx_data[7:0]};
            cur_nxt.hcnt = (cur_r.hcnt == dly) ? dly : 4'(cur_r.hcnt + 4'h1);
            if (cur_r.trail_act) begin
               cur_nxt.trail_cnt = 4'(cur_r.trail_cnt - 4'h1);
               if (cur_r.trail_cnt == 4'h1) begin
                  cur_nxt.trail_act = 1'b0;
                  cur_nxt.close = 1'b1;
               end
            end else if ((eff == pkt_pkg::MODE_SEND || eff == pkt_pkg::MODE_CUT) && cur_nxt.hcnt >= slen
                         && str_match(cur_nxt.hist, cur_r.str, slen)) begin
               if (eff == pkt_pkg::MODE_SEND && cur_r.trail != 4'h0) begin
                  cur_nxt.trail_act = 1'b1;
                  cur_nxt.trail_cnt = cur_r.trail;
               end else begin
                  cur_nxt.close = 1'b1;
               end
            end
         end
      end
      bi.wr_en = wr_go;
      bi.wr_addr = cur_r.wr;
      bi.wr_data = {wr_eop, wr_byte};
      if (wr_go) begin
         cur_nxt.wr = 10'(cur_r.wr + 10'h1);
         cur_nxt.pkt_cnt = 10'(cur_r.pkt_cnt + 10'h1);
         if (10'(cur_r.pkt_cnt + 10'h1) >= lim) begin
            commit = 1'b1;
         end
      end
      if (commit) begin
         cur_nxt.cmt = cur_nxt.wr;
         cur_nxt.pkt_cnt = 10'h0;
      end

      // ----------------------------------------
      // network drain, one byte per two cycles
      // ----------------------------------------
      if (cur_r.out_v && net_ready) begin
         cur_nxt.out_v = 1'b0;
      end
      if (cur_r.fetch) begin
         cur_nxt.out_v = 1'b1;
         cur_nxt.out_d = bi.rd_data[7:0];
         cur_nxt.out_eop = bi.rd_data[8];
      end
      cur_nxt.fetch = cur_r.rd != cur_r.cmt && !cur_r.fetch && (!cur_r.out_v || net_ready);
      if (cur_nxt.fetch) begin
         cur_nxt.rd = 10'(cur_r.rd + 10'h1);
      end

      // ----------------------------------------
      // transmit pacing
      // ----------------------------------------
      tx_done = 1'b0;
      if (cur_r.ser_v && ser_tx_ready) begin
         cur_nxt.ser_v = 1'b0;
         if (cur_r.ser_eop && eff == pkt_pkg::MODE_IDLE) begin
            cur_nxt.tx_gap = 1'b1;
            cur_nxt.tx_sub = 24'h0;
            cur_nxt.tx_u = 16'h0;
         end else begin
            cur_nxt.tx_rdy = 1'b1;
         end
      end
      if (cur_r.tx_gap) begin
         {tx_done, cur_nxt.tx_sub, cur_nxt.tx_u} =
            pkt_pkg::timer_step(cur_r.tx_sub, cur_r.tx_u, cur_r.tx_idle, ulen, tx_tick);
         if (tx_done) begin
            cur_nxt.tx_gap = 1'b0;
            cur_nxt.tx_rdy = 1'b1;
         end
      end
      if (cur_r.tx_rdy && tx_in_valid) begin
         cur_nxt.tx_rdy = 1'b0;
         cur_nxt.ser_v = 1'b1;
         cur_nxt.ser_d = tx_in_data;
         cur_nxt.ser_eop = tx_in_eop;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_r <= RST;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign wb_ack_o = cur_r.wb_ack;
   assign wb_dat_o = cur_r.wb_dat;
   assign net_valid = cur_r.out_v;
   assign net_data = cur_r.out_d;
   assign end_of_packet_marker = cur_r.out_eop;
   assign tx_in_ready = cur_r.tx_rdy;
   assign ser_tx_valid = cur_r.ser_v;
   assign ser_tx_data = cur_r.ser_d;
   assign modem_server_mode = cur_r.modem_o;
   assign parity_check_en = cur_r.par_o;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_none_no_mark;
      @(posedge clk) disable iff (!resetn) (eff == pkt_pkg::MODE_NONE && bi.wr_en) |-> !bi.wr_data[8];
   endproperty
   a_none_no_mark: assert property (p_none_no_mark) else $error("end mark written in stream mode");
   property p_idle_on_tick;
      @(posedge clk) disable iff (!resetn) idle_fire |-> rx_tick && cur_r.rx_u >= cur_r.rx_idle;
   endproperty
   a_idle_on_tick: assert property (p_idle_on_tick) else $error("idle close off the tick grid");
   property p_rx_restart;
      @(posedge clk) disable iff (!resetn) rx_fire |=> cur_r.rx_run && cur_r.rx_u == 16'h0 && cur_r.rx_sub == 24'h0;
   endproperty
   a_rx_restart: assert property (p_rx_restart) else $error("idle timer not restarted");
   property p_tx_quiet;
      @(posedge clk) disable iff (!resetn) (cur_r.tx_gap && !tx_tick) |=> cur_r.tx_gap && !tx_in_ready;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("transmit gap ended without a tick");
   property p_send_keep;
      @(posedge clk) disable iff (!resetn) (cur_r.close && eff == pkt_pkg::MODE_SEND && cur_r.hcnt != 4'h0)
         |-> bi.wr_en && bi.wr_data == {1'b1, cur_r.hist[0]};
   endproperty
   a_send_keep: assert property (p_send_keep) else $error("terminator not kept with mark");
   property p_cut_drop;
      @(posedge clk) disable iff (!resetn) (cur_r.close && eff == pkt_pkg::MODE_CUT && cur_r.hcnt == dly)
         |-> bi.wr_en && bi.wr_data == {1'b1, cur_r.hist[slen]} ##1 cur_r.hcnt == 4'h0;
   endproperty
   a_cut_drop: assert property (p_cut_drop) else $error("terminator not removed");
   property p_string_no_limit;
      @(posedge clk) disable iff (!resetn)
         (eff == pkt_pkg::MODE_SEND && bi.wr_en && !bi.wr_data[8] && 10'(cur_r.pkt_cnt + 10'h1) < lim)
         |=> cur_r.cmt == $past(cur_r.cmt);
   endproperty
   a_string_no_limit: assert property (p_string_no_limit) else $error("string packet released early");
   property p_ninth_start;
      @(posedge clk) disable iff (!resetn) (rx_fire && eff == pkt_pkg::MODE_NINTH && !rx_data[8] && cur_r.hcnt != 4'h0)
         |-> bi.wr_en && bi.wr_data[8] ##1 cur_r.cmt == cur_r.wr;
   endproperty
   a_ninth_start: assert property (p_ninth_start) else $error("ninth-bit start not closing packet");
   property p_ninth_parity;
      @(posedge clk) disable iff (!resetn) (eff == pkt_pkg::MODE_NINTH) |=> !parity_check_en;
   endproperty
   a_ninth_parity: assert property (p_ninth_parity) else $error("parity checked in ninth-bit mode");
   property p_level;
      @(posedge clk) disable iff (!resetn) 10'(cur_r.wr - cur_r.rd) <= pkt_pkg::BUF_MAX && cur_r.pkt_cnt < lim;
   endproperty
   a_level: assert property (p_level) else $error("buffer over its limit");
   property p_trail_end;
      @(posedge clk) disable iff (!resetn) (rx_fire && cur_r.trail_act && cur_r.trail_cnt == 4'h1)
         |=> cur_r.close && !cur_r.trail_act;
   endproperty
   a_trail_end: assert property (p_trail_end) else $error("trailing count not closing packet");
   property p_ext_gate;
      @(posedge clk) disable iff (!resetn) (bi.wr_en && bi.wr_data[8]) |-> cur_r.ext_en && ext_agreed;
   endproperty
   a_ext_gate: assert property (p_ext_gate) else $error("packet end without extension");
   property p_modem;
      @(posedge clk) disable iff (!resetn) $changed(cur_r.modem) |=> modem_server_mode == $past(cur_r.modem);
   endproperty
   a_modem: assert property (p_modem) else $error("modem server select not following");
   property p_mark_out;
      @(posedge clk) disable iff (!resetn) cur_r.fetch |=> net_valid && end_of_packet_marker == $past(bi.rd_data[8]);
   endproperty
   a_mark_out: assert property (p_mark_out) else $error("end mark lost on output");
endmodule

// file: verification/ser_dev.sv
`timescale 1ns/1ps
module ser_dev (
   output logic rx_valid,
   output logic [8:0] rx_data,
   output logic ser_tx_ready,
   input wire logic clk
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 9'h1ff;
      ser_tx_ready = 1'b1;
   end
   // one character, then a gap well past the two-cycle minimum; callers keep packets short
   task automatic send(input logic [8:0] c);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= c;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~c;
      repeat (3) @(posedge clk);
   endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, agr = 1'b0, nr = 1'b0, tv = 1'b0, te = 1'b0;
   logic ack, nv, eop, rxv, txr, ms, pc, tir, sv;
   logic [3:0] sel = 4'hf;
   logic [7:0] adr = 8'h00, nd, sd, td = 8'h00;
   logic [31:0] wd = 32'h0, rd, q;
   logic [8:0] rxd;
   int mismatches = 0, n_compared = 0;
   always #20 clk = ~clk;
   ser_dev u_dev (.rx_valid(rxv), .rx_data(rxd), .ser_tx_ready(txr), .clk(clk));
   serial_rx_packetizer u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rd), .rx_valid(rxv),
      .rx_data(rxd), .ext_agreed(agr), .net_valid(nv), .net_data(nd), .end_of_packet_marker(eop),
      .net_ready(nr), .tx_in_valid(tv), .tx_in_data(td), .tx_in_eop(te), .tx_in_ready(tir),
      .ser_tx_valid(sv), .ser_tx_data(sd), .ser_tx_ready(txr), .modem_server_mode(ms), .parity_check_en(pc));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // waits are bounded; a hang ends the run as a mismatch
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      q = rd;
      cyc <= 1'b0;
      if (i >= 50) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // network side is ready only while a get waits, so each byte stands until it is looked at
   task automatic get(input logic [8:0] e);
      int i;
      i = 0;
      @(posedge clk);
      nr <= 1'b1;
      do begin
         @(posedge clk);
         i++;
      end while (nv !== 1'b1 && i < 5000);
      nr <= 1'b0;
      if (i >= 5000) begin
         mismatches++;
         wrap_up();
      end else begin
         check({eop, nd}, e);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      wb(1'b0, 8'h00, 32'h0);
      check(q, 32'h0000a000);
      wb(1'b0, 8'h18, 32'h0);
      check(q, 32'h0a2c);
      wb(1'b0, 8'h24, 32'h0);
      check(q, 32'h0);
      wb(1'b1, 8'h04, 32'h1234);
      sel <= 4'h1;
      wb(1'b1, 8'h04, 32'h5678);
      sel <= 4'hf;
      wb(1'b0, 8'h04, 32'h0);
      check(q, 32'h1278);
   endtask
   task automatic t_none;
      wb(1'b1, 8'h00, 32'ha102);
      u_dev.send(9'h041);
      get(9'h041);
      u_dev.send(9'h00d);
      get(9'h00d);
   endtask
   task automatic t_send;
      agr <= 1'b1;
      u_dev.send(9'h041);
      u_dev.send(9'h00d);
      get(9'h041);
      get(9'h10d);
      wb(1'b1, 8'h14, 32'h01000000);
      u_dev.send(9'h043);
      u_dev.send(9'h00d);
      u_dev.send(9'h055);
      get(9'h043);
      get(9'h00d);
      get(9'h155);
      wb(1'b1, 8'h14, 32'h2);
      u_dev.send(9'h044);
      u_dev.send(9'h045);
      u_dev.send(9'h046);
      get(9'h044);
      get(9'h045);
      u_dev.send(9'h00d);
      get(9'h046);
      get(9'h10d);
      wb(1'b1, 8'h14, 32'h0);
      wb(1'b1, 8'h00, 32'ha103);
      u_dev.send(9'h042);
      u_dev.send(9'h00d);
      get(9'h142);
   endtask
   task automatic t_idle;
      wb(1'b1, 8'h04, 32'h1);
      wb(1'b1, 8'h00, 32'ha121);
      u_dev.send(9'h046);
      u_dev.send(9'h047);
      get(9'h046);
      get(9'h147);
   endtask
   // idle mode, bit units: after a packet end the transmitter stays quiet one bit time, then up to a tick
   task automatic t_tx;
      int n;
      wb(1'b1, 8'h08, 32'h1);
      tv <= 1'b1;
      td <= 8'h5a;
      te <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tir !== 1'b1 && n < 50);
      tv <= 1'b0;
      @(posedge clk);
      check({tir, sv, sd}, 10'h15a);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tir !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         mismatches++;
         wrap_up();
      end else begin
         check(n > int'(pkt_pkg::RST_BIT_CYC), 1'b1);
         check(n < int'(pkt_pkg::RST_BIT_CYC) + pkt_pkg::CLK_HZ / pkt_pkg::TX_TICK_HZ + 4, 1'b1);
      end
   endtask
   task automatic t_ninth;
      wb(1'b1, 8'h00, 32'ha600);
      repeat (2) @(posedge clk);
      check({ms, pc}, 2'b11);
      wb(1'b1, 8'h00, 32'ha504);
      repeat (2) @(posedge clk);
      check(pc, 1'b0);
      u_dev.send(9'h041);
      u_dev.send(9'h142);
      u_dev.send(9'h043);
      get(9'h041);
      get(9'h142);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_none();
      t_send();
      t_idle();
      t_tx();
      t_ninth();
      wrap_up();
   end
endmodule
